// ==== overlay_regs_pkg.sv ====
// Constants, field layouts and carrier types for the display overlay register set.
// Functional notes
// [R1] Start field 0 means memory size minus 1024; n means memory size minus n*8192.
// [R2] In ink or special cursor modes, software keeps the overlay clear of the panel buffer.
// [R3] Software may use start field zero for ordinary cursor modes.
// [R4] A new start address takes effect only when the next vertical non-display period starts.
// [R5] Horizontal sign bit set means negative; software keeps a negative magnitude at most 63.
// [R6] Horizontal position is 10 bits: low byte plus two low bits of the next register.
// [R7] Vertical sign bit set means negative; software keeps a negative magnitude at most 63.
// [R8] Vertical position is 10 bits: low byte plus two low bits of the next register.
// [R9] Positions are used only in cursor mode and ignored otherwise.
// [R10] Horizontal and low vertical writes wait in shadow until high vertical write and blanking.
// [R11] A high vertical write commits at the start of the next vertical non-display period.
// [R12] Colour 0 blue is five bits in the low bits of its register.
// [R13] Colour 0 green is six bits in the low bits of its register.
// [R14] Colour 0 red is five bits in the low bits of its register.
// [R15] Colour 1 blue is five bits in the low bits of its read-write register.
// [R16] Mode field: 00 inactive, 01 cursor, 10 ink, 11 reserved.
// [R17] Software programs both positions to zero while in ink mode.
package overlay_regs_pkg;

	localparam logic [7:0] OFS_MODE       = 8'h80;
	localparam logic [7:0] OFS_START      = 8'h81;
	localparam logic [7:0] OFS_HPOS_LOW   = 8'h82;
	localparam logic [7:0] OFS_HPOS_HIGH  = 8'h83;
	localparam logic [7:0] OFS_VPOS_LOW   = 8'h84;
	localparam logic [7:0] OFS_VPOS_HIGH  = 8'h85;
	localparam logic [7:0] OFS_C0_BLUE    = 8'h86;
	localparam logic [7:0] OFS_C0_GREEN   = 8'h87;
	localparam logic [7:0] OFS_C0_RED     = 8'h88;
	localparam logic [7:0] OFS_STATUS     = 8'h89;
	localparam logic [7:0] OFS_C1_BLUE    = 8'h8A;

	localparam int SIGN_BIT        = 7;
	localparam int POS_HIGH_BITS   = 2;
	localparam int POS_W           = 10;
	localparam int BLUE_W          = 5;
	localparam int GREEN_W         = 6;
	localparam int RED_W           = 5;
	localparam int STAT_POS_PEND   = 0;
	localparam int STAT_START_PEND = 1;

	localparam int ZERO_START_GAP  = 1024;
	localparam int BLOCK_SHIFT     = 13;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	typedef enum logic [1:0] {
		MODE_INACTIVE = 2'b00,
		MODE_CURSOR   = 2'b01,
		MODE_INK      = 2'b10,
		MODE_RESERVED = 2'b11
	} overlay_mode_t;

	typedef struct packed {
		logic             sign;
		logic [POS_W-1:0] mag;
	} cursor_pos_t;

	typedef struct packed {
		logic [BLUE_W-1:0]  blue;
		logic [GREEN_W-1:0] green;
		logic [RED_W-1:0]   red;
	} overlay_color_t;

endpackage : overlay_regs_pkg

// ==== overlay_regs.sv ====
// Overlay cursor/ink register bank with blanking-synchronised shadow commit.
`timescale 1ns/1ps
module overlay_regs
#(
	parameter int ADDR_W = 22
)
(
	// Clock and reset
	input  wire logic                                    sys_clk,
	input  wire logic                                    rst_n,
	// Register port
	input  wire logic [7:0]                              reg_addr,
	input  wire logic [7:0]                              reg_wdata,
	input  wire logic                                    reg_wr,
	input  wire logic                                    reg_rd,
	output logic      [7:0]                              reg_rdata,
	// Display timing and memory
	input  wire logic                                    vert_nondisplay,
	input  wire logic [ADDR_W-1:0]                       mem_size,
	// Overlay outputs
	output overlay_regs_pkg::overlay_mode_t              overlay_mode,
	output logic      [ADDR_W-1:0]                       overlay_start,
	output logic                                         cursor_enable,
	output logic signed [overlay_regs_pkg::POS_W:0]      cursor_x,
	output logic signed [overlay_regs_pkg::POS_W:0]      cursor_y,
	output overlay_regs_pkg::overlay_color_t             color0,
	output logic      [overlay_regs_pkg::BLUE_W-1:0]     color1_blue
);

	// Software-visible register images, plus the previous blanking sample.
	logic [1:0]                               mode_reg;
	logic [7:0]                               start_shadow;
	logic [7:0]                               hpos_low;
	logic [7:0]                               hpos_high;
	logic [7:0]                               vpos_low;
	logic [7:0]                               vpos_high;
	logic [overlay_regs_pkg::BLUE_W-1:0]      c0_blue;
	logic [overlay_regs_pkg::GREEN_W-1:0]     c0_green;
	logic [overlay_regs_pkg::RED_W-1:0]       c0_red;
	logic [overlay_regs_pkg::BLUE_W-1:0]      c1_blue;
	logic                                     pos_pending;
	logic                                     start_pending;
	logic                                     vnd_prev;
	// Values in use by the display.
	logic [7:0]                               start_active;
	overlay_regs_pkg::cursor_pos_t            hpos_active;
	overlay_regs_pkg::cursor_pos_t            vpos_active;

	logic [1:0]                               next_mode_reg;
	logic [7:0]                               next_start_shadow;
	logic [7:0]                               next_hpos_low;
	logic [7:0]                               next_hpos_high;
	logic [7:0]                               next_vpos_low;
	logic [7:0]                               next_vpos_high;
	logic [overlay_regs_pkg::BLUE_W-1:0]      next_c0_blue;
	logic [overlay_regs_pkg::GREEN_W-1:0]     next_c0_green;
	logic [overlay_regs_pkg::RED_W-1:0]       next_c0_red;
	logic [overlay_regs_pkg::BLUE_W-1:0]      next_c1_blue;
	logic                                     next_pos_pending;
	logic                                     next_start_pending;
	logic [7:0]                               next_start_active;
	overlay_regs_pkg::cursor_pos_t            next_hpos_active;
	overlay_regs_pkg::cursor_pos_t            next_vpos_active;
	logic [7:0]                               next_rdata;
	logic [ADDR_W-1:0]                        next_overlay_start;
	logic signed [overlay_regs_pkg::POS_W:0]  next_cursor_x;
	logic signed [overlay_regs_pkg::POS_W:0]  next_cursor_y;
	logic                                     blank_start;
	logic [ADDR_W-1:0]                        start_gap;

	// The blanking input comes from timing logic on this clock, so only its rising edge is needed.
	assign blank_start = vert_nondisplay & ~vnd_prev;

	always_comb
	begin
		next_mode_reg      = mode_reg;
		next_start_shadow  = start_shadow;
		next_hpos_low      = hpos_low;
		next_hpos_high     = hpos_high;
		next_vpos_low      = vpos_low;
		next_vpos_high     = vpos_high;
		next_c0_blue       = c0_blue;
		next_c0_green      = c0_green;
		next_c0_red        = c0_red;
		next_c1_blue       = c1_blue;
		next_pos_pending   = pos_pending;
		next_start_pending = start_pending;
		next_start_active  = start_active;
		next_hpos_active   = hpos_active;
		next_vpos_active   = vpos_active;

		// Commit happens first so that a write in the same cycle leaves its pending flag set.
		if (blank_start && start_pending)
		begin
			next_start_active  = start_shadow; // R4
			next_start_pending = 1'b0;
		end
		if (blank_start && pos_pending)
		begin
			next_hpos_active.sign = hpos_high[overlay_regs_pkg::SIGN_BIT]; // R5
			next_hpos_active.mag  = {hpos_high[overlay_regs_pkg::POS_HIGH_BITS-1:0], hpos_low}; // R6
			next_vpos_active.sign = vpos_high[overlay_regs_pkg::SIGN_BIT]; // R7
			next_vpos_active.mag  = {vpos_high[overlay_regs_pkg::POS_HIGH_BITS-1:0], vpos_low}; // R8
			next_pos_pending      = 1'b0; // R11
		end

		if (reg_wr)
		begin
			case (reg_addr)
				overlay_regs_pkg::OFS_MODE:
					next_mode_reg = reg_wdata[1:0]; // R16
				overlay_regs_pkg::OFS_START:
				begin
					next_start_shadow  = reg_wdata;
					next_start_pending = 1'b1; // R4
				end
				overlay_regs_pkg::OFS_HPOS_LOW:
					next_hpos_low = reg_wdata; // R10
				overlay_regs_pkg::OFS_HPOS_HIGH:
					next_hpos_high = reg_wdata; // R10
				overlay_regs_pkg::OFS_VPOS_LOW:
					next_vpos_low = reg_wdata; // R10
				overlay_regs_pkg::OFS_VPOS_HIGH:
				begin
					next_vpos_high   = reg_wdata;
					next_pos_pending = 1'b1; // R10 R11
				end
				overlay_regs_pkg::OFS_C0_BLUE:
					next_c0_blue = reg_wdata[overlay_regs_pkg::BLUE_W-1:0]; // R12
				overlay_regs_pkg::OFS_C0_GREEN:
					next_c0_green = reg_wdata[overlay_regs_pkg::GREEN_W-1:0]; // R13
				overlay_regs_pkg::OFS_C0_RED:
					next_c0_red = reg_wdata[overlay_regs_pkg::RED_W-1:0]; // R14
				overlay_regs_pkg::OFS_C1_BLUE:
					next_c1_blue = reg_wdata[overlay_regs_pkg::BLUE_W-1:0]; // R15
				default:
					next_mode_reg = mode_reg;
			endcase
		end
	end

	// Readback shows the last values written, not the committed ones; status shows what waits.
	always_comb
	begin
		next_rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				overlay_regs_pkg::OFS_MODE:      next_rdata = {6'h00, mode_reg};
				overlay_regs_pkg::OFS_START:     next_rdata = start_shadow;
				overlay_regs_pkg::OFS_HPOS_LOW:  next_rdata = hpos_low;
				overlay_regs_pkg::OFS_HPOS_HIGH: next_rdata = {hpos_high[7], 5'h00, hpos_high[1:0]};
				overlay_regs_pkg::OFS_VPOS_LOW:  next_rdata = vpos_low;
				overlay_regs_pkg::OFS_VPOS_HIGH: next_rdata = {vpos_high[7], 5'h00, vpos_high[1:0]};
				overlay_regs_pkg::OFS_C0_BLUE:   next_rdata = {3'h0, c0_blue};
				overlay_regs_pkg::OFS_C0_GREEN:  next_rdata = {2'h0, c0_green};
				overlay_regs_pkg::OFS_C0_RED:    next_rdata = {3'h0, c0_red};
				overlay_regs_pkg::OFS_STATUS:    next_rdata = {6'h00, start_pending, pos_pending};
				overlay_regs_pkg::OFS_C1_BLUE:   next_rdata = {3'h0, c1_blue};
				default:                         next_rdata = 8'h00;
			endcase
		end
	end

	// Overlay address and signed positions derived from committed values.
	always_comb
	begin
		if (start_active == 8'h00)
			start_gap = ADDR_W'(overlay_regs_pkg::ZERO_START_GAP); // R1
		else
			start_gap = ADDR_W'(start_active) << overlay_regs_pkg::BLOCK_SHIFT; // R1
		next_overlay_start = mem_size - start_gap; // R1

		next_cursor_x = '0;
		next_cursor_y = '0;
		// Positions only mean something in cursor mode; elsewhere they are forced to zero.
		if (overlay_regs_pkg::overlay_mode_t'(mode_reg) == overlay_regs_pkg::MODE_CURSOR) // R9
		begin
			next_cursor_x = hpos_active.sign ? -$signed({1'b0, hpos_active.mag})
			                                 : $signed({1'b0, hpos_active.mag}); // R5
			next_cursor_y = vpos_active.sign ? -$signed({1'b0, vpos_active.mag})
			                                 : $signed({1'b0, vpos_active.mag}); // R7
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			mode_reg      <= 2'h0;
			start_shadow  <= overlay_regs_pkg::RESET_BYTE;
			hpos_low      <= overlay_regs_pkg::RESET_BYTE;
			hpos_high     <= overlay_regs_pkg::RESET_BYTE;
			vpos_low      <= overlay_regs_pkg::RESET_BYTE;
			vpos_high     <= overlay_regs_pkg::RESET_BYTE;
			c0_blue       <= '0;
			c0_green      <= '0;
			c0_red        <= '0;
			c1_blue       <= '0;
			pos_pending   <= 1'b0;
			start_pending <= 1'b0;
			vnd_prev      <= 1'b0;
			start_active  <= overlay_regs_pkg::RESET_BYTE;
			hpos_active   <= '0;
			vpos_active   <= '0;
			reg_rdata     <= 8'h00;
			overlay_start <= '0;
			cursor_x      <= '0;
			cursor_y      <= '0;
		end
		else
		begin
			mode_reg      <= next_mode_reg;
			start_shadow  <= next_start_shadow;
			hpos_low      <= next_hpos_low;
			hpos_high     <= next_hpos_high;
			vpos_low      <= next_vpos_low;
			vpos_high     <= next_vpos_high;
			c0_blue       <= next_c0_blue;
			c0_green      <= next_c0_green;
			c0_red        <= next_c0_red;
			c1_blue       <= next_c1_blue;
			pos_pending   <= next_pos_pending;
			start_pending <= next_start_pending;
			vnd_prev      <= vert_nondisplay;
			start_active  <= next_start_active;
			hpos_active   <= next_hpos_active;
			vpos_active   <= next_vpos_active;
			reg_rdata     <= next_rdata;
			overlay_start <= next_overlay_start;
			cursor_x      <= next_cursor_x;
			cursor_y      <= next_cursor_y;
		end
	end

	assign overlay_mode  = overlay_regs_pkg::overlay_mode_t'(mode_reg); // R16
	assign cursor_enable = (overlay_mode == overlay_regs_pkg::MODE_CURSOR); // R9
	assign color0        = '{blue: c0_blue, green: c0_green, red: c0_red};
	assign color1_blue   = c1_blue;

endmodule : overlay_regs

// ==== overlay_regs_checker.sv ====
// Concurrent checks on the ports of the overlay register bank.
`timescale 1ns/1ps
module overlay_regs_checker
#(
	parameter int ADDR_W = 22
)
(
	input wire logic                                   sys_clk,
	input wire logic                                   rst_n,
	input wire logic [7:0]                             reg_addr,
	input wire logic [7:0]                             reg_wdata,
	input wire logic                                   reg_wr,
	input wire logic                                   reg_rd,
	input wire logic [7:0]                             reg_rdata,
	input wire logic                                   vert_nondisplay,
	input wire logic [ADDR_W-1:0]                      mem_size,
	input wire overlay_regs_pkg::overlay_mode_t        overlay_mode,
	input wire logic [ADDR_W-1:0]                      overlay_start,
	input wire logic                                   cursor_enable,
	input wire logic signed [overlay_regs_pkg::POS_W:0] cursor_x,
	input wire logic signed [overlay_regs_pkg::POS_W:0] cursor_y,
	input wire overlay_regs_pkg::overlay_color_t       color0,
	input wire logic [overlay_regs_pkg::BLUE_W-1:0]    color1_blue
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Blank start delayed by two edges, the moment a committed value reaches the outputs.
	logic vn_d;
	logic st1;
	logic st2;
	always_ff @(posedge sys_clk)
	begin
		vn_d <= vert_nondisplay;
		st1  <= vert_nondisplay & ~vn_d;
		st2  <= st1;
	end
	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read slot");
	property p_unmapped; reg_rd && (reg_addr > overlay_regs_pkg::OFS_C1_BLUE || reg_addr < overlay_regs_pkg::OFS_MODE)
		|=> reg_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_en; reg_wr && reg_addr == overlay_regs_pkg::OFS_MODE |=> overlay_mode == $past(reg_wdata[1:0])
		&& cursor_enable == ($past(reg_wdata[1:0]) == 2'h1); endproperty
	a_en: assert property (p_en) else $error("cursor enable does not follow mode");
	property p_pos_off; !$past(cursor_enable) |-> cursor_x == 0 && cursor_y == 0; endproperty
	a_pos_off: assert property (p_pos_off) else $error("position shown outside cursor mode");
	property p_hi; reg_rd && reg_addr == overlay_regs_pkg::OFS_HPOS_HIGH |=> reg_rdata[6:2] == 5'h00; endproperty
	a_hi: assert property (p_hi) else $error("unused high position bits not zero");
	property p_c0b; reg_wr && reg_addr == overlay_regs_pkg::OFS_C0_BLUE
		|=> {3'h0, color0.blue} == ($past(reg_wdata) & 8'h1F); endproperty
	a_c0b: assert property (p_c0b) else $error("colour 0 blue not taken");
	property p_c0g; reg_wr && reg_addr == overlay_regs_pkg::OFS_C0_GREEN
		|=> {2'h0, color0.green} == ($past(reg_wdata) & 8'h3F); endproperty
	a_c0g: assert property (p_c0g) else $error("colour 0 green not taken");
	property p_c1b; reg_wr && reg_addr == overlay_regs_pkg::OFS_C1_BLUE
		|=> {3'h0, color1_blue} == ($past(reg_wdata) & 8'h1F); endproperty
	a_c1b: assert property (p_c1b) else $error("colour 1 blue not taken");
	property p_start_hold; $changed(overlay_start) |-> st2 || !$past(rst_n, 2); endproperty
	a_start_hold: assert property (p_start_hold) else $error("start moved outside blank start");
	property p_pos_hold; ($changed(cursor_x) || $changed(cursor_y)) && $past(cursor_enable)
		&& $past(cursor_enable, 2) |-> st2; endproperty
	a_pos_hold: assert property (p_pos_hold) else $error("position moved outside blank start");
	c_commit: cover property (st2 && cursor_enable && cursor_x < 0);
	c_start: cover property ($changed(overlay_start) && st2);
	c_rd: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule : overlay_regs_checker
bind overlay_regs overlay_regs_checker #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.vert_nondisplay(vert_nondisplay), .mem_size(mem_size), .overlay_mode(overlay_mode),
	.overlay_start(overlay_start), .cursor_enable(cursor_enable), .cursor_x(cursor_x), .cursor_y(cursor_y),
	.color0(color0), .color1_blue(color1_blue));

// ==== tb.sv ====
// Self-checking bench for the overlay register bank.
`timescale 1ns/1ps
module tb;
	localparam logic [21:0] MEM = 22'h200000;
	logic                            sys_clk, rst_n, reg_wr, reg_rd, vn, cursor_enable, s;
	logic                            rd_d = 1'b0;
	logic [7:0]                      reg_addr, reg_wdata, reg_rdata, b;
	logic [7:0]                      q[$];
	logic [7:0]                      d[4];
	logic [21:0]                     overlay_start, e, prev;
	logic [9:0]                      m;
	logic [4:0]                      color1_blue;
	logic signed [10:0]              cursor_x, cursor_y, ex, px;
	overlay_regs_pkg::overlay_mode_t overlay_mode;
	overlay_regs_pkg::overlay_color_t color0;
	int                              err_count, num_checks;
	logic [7:0] ofs[4] = '{overlay_regs_pkg::OFS_C0_BLUE, overlay_regs_pkg::OFS_C0_GREEN,
		overlay_regs_pkg::OFS_C0_RED, overlay_regs_pkg::OFS_C1_BLUE};
	logic [7:0] msk[4] = '{8'h1F, 8'h3F, 8'h1F, 8'h1F};
	overlay_regs #(.ADDR_W(22)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.vert_nondisplay(vn), .mem_size(MEM), .overlay_mode(overlay_mode), .overlay_start(overlay_start),
		.cursor_enable(cursor_enable), .cursor_x(cursor_x), .cursor_y(cursor_y), .color0(color0),
		.color1_blue(color1_blue));
	task automatic chk(input string n, input logic [21:0] v, input logic [21:0] x);
		num_checks++;
		if (v !== x)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, v);
		end
	endtask : chk
	task automatic end_of_test();
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		q.push_back(x);
		@(posedge sys_clk);
	endtask : rd
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask : idle
	task automatic blank();
		vn <= 1'b1;
		idle(4);
		vn <= 1'b0;
		idle(2);
	endtask : blank
	// Read data is due exactly one cycle after the strobe, so the oldest note is taken then.
	always @(posedge sys_clk)
	begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1)
			chk("reg_rdata", 22'(reg_rdata), 22'(q.pop_front()));
	end
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial
	begin
		#50000;
		err_count++;
		end_of_test();
	end
	initial
	begin
		{rst_n, reg_wr, reg_rd, vn, reg_addr, reg_wdata} = '0;
		b = 8'($urandom(32'h0f6dda98));
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		idle(2);
		prev = MEM - 22'd1024;
		chk("start_reset", overlay_start, prev);
		for (int i = 0; i < 4; i++)
		begin
			d[i] = 8'($urandom);
			wr(ofs[i], d[i]);
			rd(ofs[i], d[i] & msk[i]);
		end
		wr(8'h8C, 8'hFF);
		rd(8'h8C, 8'h00);
		rd(8'h7F, 8'h00);
		idle(2);
		chk("color0", 22'(color0), 22'({d[0][4:0], d[1][5:0], d[2][4:0]}));
		chk("color1_blue", 22'(color1_blue), 22'(d[3][4:0]));
		// Cursor mode is on while the start field steps through 1, 255, a random middle value and zero.
		wr(overlay_regs_pkg::OFS_MODE, 8'h01);
		for (int j = 0; j < 4; j++)
		begin
			b = (j == 0) ? 8'h01 : (j == 1) ? 8'hFF : (j == 2) ? 8'($urandom_range(254, 2)) : 8'h00;
			e = (b == 8'h00) ? MEM - 22'd1024 : MEM - 22'(b) * 22'd8192;
			wr(overlay_regs_pkg::OFS_START, b);
			rd(overlay_regs_pkg::OFS_STATUS, 8'h02);
			idle(3);
			chk("start_hold", overlay_start, prev);
			blank();
			chk("start", overlay_start, e);
			prev = e;
		end
		px = '0;
		for (int k = 0; k < 3; k++)
		begin
			s = (k != 0);
			m = (k == 0) ? 10'($urandom) : (k == 1) ? 10'd63 : 10'($urandom_range(62, 1));
			wr(overlay_regs_pkg::OFS_HPOS_LOW, m[7:0]);
			wr(overlay_regs_pkg::OFS_HPOS_HIGH, {s, 5'h00, m[9:8]});
			wr(overlay_regs_pkg::OFS_VPOS_LOW, m[7:0]);
			idle(1);
			blank();
			chk("x_shadow", 22'(cursor_x), 22'(px));
			wr(overlay_regs_pkg::OFS_VPOS_HIGH, {s, 5'h00, m[9:8]});
			rd(overlay_regs_pkg::OFS_HPOS_HIGH, {s, 5'h00, m[9:8]});
			rd(overlay_regs_pkg::OFS_STATUS, 8'h01);
			idle(3);
			chk("y_hold", 22'(cursor_y), 22'(px));
			blank();
			ex = s ? -$signed({1'b0, m}) : $signed({1'b0, m});
			chk("cursor_x", 22'(cursor_x), 22'(ex));
			chk("cursor_y", 22'(cursor_y), 22'(ex));
			px = ex;
		end
		for (int i = 0; i < 4; i++)
		begin
			// Before ink mode the overlay moves below a notional top panel buffer and both positions go to zero.
			if (i == 2)
			begin
				wr(overlay_regs_pkg::OFS_START, 8'h04);
				wr(overlay_regs_pkg::OFS_HPOS_LOW, 8'h00);
				wr(overlay_regs_pkg::OFS_HPOS_HIGH, 8'h00);
				wr(overlay_regs_pkg::OFS_VPOS_LOW, 8'h00);
				wr(overlay_regs_pkg::OFS_VPOS_HIGH, 8'h00);
				blank();
				px = '0;
				chk("start_ink", overlay_start, MEM - 22'h008000);
				chk("x_zero", 22'(cursor_x), 22'h0);
			end
			wr(overlay_regs_pkg::OFS_MODE, 8'(i));
			rd(overlay_regs_pkg::OFS_MODE, 8'(i));
			idle(2);
			chk("mode", 22'(overlay_mode), 22'(i));
			chk("x_mode", 22'(cursor_x), (i == 1) ? 22'(px) : 22'h0);
		end
		rst_n <= 1'b0;
		idle(2);
		rst_n <= 1'b1;
		idle(2);
		chk("color0_reset", 22'(color0), 22'h0);
		rd(overlay_regs_pkg::OFS_C0_BLUE, 8'h00);
		idle(2);
		chk("start_reset2", overlay_start, MEM - 22'd1024);
		end_of_test();
	end
endmodule : tb
